// ---- hdl/mmd_decoder.sv ----
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - small mode forces fetches into page ffh
// - large mode fetches from any page
// - pin inactive sends rom window inside
// - pin low sends rom window outside
// - fold bit shows rom in page 00h
// - fold clear leaves page 00h external
// - internal ram seen in both pages
// - redirect bit sends ffh ram alias out
// - upper register ram above lower file
// - lowest 256 bytes are lower registers
// - unoccupied addresses go to external bus
// - address bit 17 on port bit 1
// - boot page ffh shows low page bits
// - size mode latched at reset release
// - registers and sfrs always internal in page 00h
module mmd_decoder
#(
   parameter int ADDR_W = 24,
   parameter int CNT_W  = 16
)
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic [11:0]       paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // straps and pins
   input  wire logic              memory_size_mode_bit,
   input  wire logic              rom_fold_select_bit,
   input  wire logic              external_access_pin_n,
   // core access
   input  wire logic              acc_valid,
   input  wire logic              acc_fetch,
   input  wire logic [ADDR_W-1:0] acc_addr,
   // target side
   output var  logic              tgt_valid,
   output var  logic [3:0]        tgt_sel,
   output var  logic [ADDR_W-1:0] tgt_addr,
   output var  logic [3:0]        extended_address_port
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   generate
      if (ADDR_W != 24)
      begin : g_bad_addr
         $error("address width must be 24");
      end
      if (CNT_W != 16)
      begin : g_bad_cnt
         $error("counter width must be 16");
      end
   endgenerate

   // ----------------------------------------
   // state
   // ----------------------------------------
   mmd_pkg::mmd_state_t state_reg;
   logic              size_mode_reg;
   logic              rom_alias_enable;
   logic [7:0]        internal_ram_control_reg;
   logic              internal_ram_redirect_bit;
   logic [ADDR_W-1:0] tgt_addr_reg;
   logic [3:0]        tgt_sel_reg;
   logic              tgt_valid_reg;
   logic [3:0]        port_reg;
   logic [CNT_W-1:0]  ext_cnt_reg;
   logic [CNT_W-1:0]  ext_cnt_next;
   logic [31:0]       prdata_reg;
   logic [31:0]       rd_next;
   logic              pready_reg;
   logic              pslverr_reg;
   logic              setup;
   logic              access;
   logic              mapped;

   mmd_if rt ();

   // ----------------------------------------
   // configuration capture
   // ----------------------------------------
   // straps are taken on the first edge after release, never by the reset
   // latch once, hold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg        <= mmd_pkg::ST_HOLD;
         size_mode_reg    <= 1'b0;
         rom_alias_enable <= 1'b0;
      end
      else if (state_reg == mmd_pkg::ST_HOLD)
      begin
         state_reg        <= mmd_pkg::ST_RUN;
         size_mode_reg    <= memory_size_mode_bit;
         rom_alias_enable <= rom_fold_select_bit;
      end
   end

   assign internal_ram_redirect_bit = internal_ram_control_reg[mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_REDIR];

   // ----------------------------------------
   // address routing
   // ----------------------------------------
   assign rt.addr      = acc_addr;
   assign rt.fetch     = acc_fetch;
   assign rt.size_mode = size_mode_reg;
   assign rt.alias_en  = rom_alias_enable;
   assign rt.ext_pin_n = external_access_pin_n;
   assign rt.redir     = internal_ram_redirect_bit;

   mmd_route u_route
   (
      .bus (rt.route)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tgt_valid_reg <= 1'b0;
         tgt_sel_reg   <= 4'h0;
         tgt_addr_reg  <= 24'h000000;
      end
      else
      begin
         tgt_valid_reg <= acc_valid;
         tgt_sel_reg   <= acc_valid ? rt.sel : 4'h0;
         tgt_addr_reg  <= rt.eff_addr;
      end
   end

   // low page bits on the port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_reg <= 4'h0;
      else if (acc_valid)
         port_reg <= rt.eff_addr[19:16];
   end

   assign tgt_valid             = tgt_valid_reg;
   assign tgt_sel               = tgt_sel_reg;
   assign tgt_addr              = tgt_addr_reg;
   assign extended_address_port = port_reg;

   // ----------------------------------------
   // external access counter
   // ----------------------------------------
   // a clear that meets a new access still counts that access
   always_comb
   begin
      ext_cnt_next = ext_cnt_reg;
      if (access && pwrite && paddr == mmd_pkg::OFS_STAT)
         ext_cnt_next = mmd_pkg::CNT_RST;
      if (tgt_valid_reg && tgt_sel_reg == mmd_pkg::SEL_EXT)
         ext_cnt_next = ext_cnt_next + mmd_pkg::CNT_ONE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_cnt_reg <= mmd_pkg::CNT_RST;
      else
         ext_cnt_reg <= ext_cnt_next;
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // answer fixed: pready in the first access cycle
   assign setup  = psel && !penable;
   assign access = psel && penable && pready_reg;
   assign mapped = (paddr == mmd_pkg::OFS_CFG) || (paddr == mmd_pkg::OFS_IRAMCON) ||
                   (paddr == mmd_pkg::OFS_STAT);

   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (paddr)
         mmd_pkg::OFS_CFG:
         begin
            rd_next[mmd_pkg::CFG_SIZE]   = size_mode_reg;
            rd_next[mmd_pkg::CFG_FOLD]   = rom_alias_enable;
            rd_next[mmd_pkg::CFG_EXTPIN] = external_access_pin_n;
            rd_next[mmd_pkg::CFG_RUN]    = (state_reg == mmd_pkg::ST_RUN);
         end
         mmd_pkg::OFS_IRAMCON:
            rd_next[7:0] = internal_ram_control_reg;
         mmd_pkg::OFS_STAT:
         begin
            rd_next[3:0] = tgt_sel_reg;
            rd_next[mmd_pkg::STAT_CNT_LO +: 16] = ext_cnt_reg;
         end
         default:
            rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !mapped;
         prdata_reg  <= (setup && !pwrite) ? rd_next : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         internal_ram_control_reg <= mmd_pkg::IRAMCON_RST;
      else if (access && pwrite && paddr == mmd_pkg::OFS_IRAMCON)
         internal_ram_control_reg <= pwdata[7:0];
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [7:0]  req_pg;
   logic [15:0] req_of;
   logic        req_rom;
   logic        req_ram;
   assign req_pg  = acc_addr[23:16];
   assign req_of  = acc_addr[15:0];
   assign req_rom = mmd_pkg::mmd_in_range(req_of, mmd_pkg::ROM_LO, mmd_pkg::ROM_HI);
   assign req_ram = mmd_pkg::mmd_in_range(req_of, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_LO, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_HI);

   sequence s_fetch_small;
      acc_valid && acc_fetch && size_mode_reg;
   endsequence
   sequence s_near_req;
      acc_valid && !(acc_fetch && size_mode_reg) && req_pg == mmd_pkg::PAGE_NEAR;
   endsequence
   sequence s_top_req;
      acc_valid && req_pg == mmd_pkg::PAGE_TOP;
   endsequence

   a_small_fetch_page: assert property (
      s_fetch_small |=> tgt_addr[23:16] == mmd_pkg::PAGE_TOP
                        && tgt_addr[15:0] == $past(acc_addr[15:0]))
      else $error("small mode fetch left page ffh");
   a_any_page_fetch: assert property (
      acc_valid && acc_fetch && !size_mode_reg |=> tgt_addr == $past(acc_addr))
      else $error("large mode fetch address altered");
   a_rom_internal: assert property (
      s_top_req ##0 (req_rom && external_access_pin_n) |=> tgt_sel == mmd_pkg::SEL_IROM)
      else $error("rom window not internal");
   a_pin_external: assert property (
      (s_top_req or s_near_req) ##0 (req_rom && !external_access_pin_n)
      |=> tgt_sel == mmd_pkg::SEL_EXT)
      else $error("rom window not external with pin low");
   a_fold_rom: assert property (
      s_near_req ##0 (req_rom && rom_alias_enable && external_access_pin_n)
      |=> tgt_sel == mmd_pkg::SEL_IROM)
      else $error("folded rom not seen in page 00h");
   a_nofold_ext: assert property (
      s_near_req ##0 (req_rom && !rom_alias_enable) |=> tgt_sel == mmd_pkg::SEL_EXT)
      else $error("unfolded page 00h rom range not external");
   a_ram_alias: assert property (
      ((s_top_req ##0 !internal_ram_redirect_bit) or s_near_req) ##0 req_ram
      |=> tgt_sel == mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT)
      else $error("internal ram not reached");
   a_ram_redirect: assert property (
      s_top_req ##0 (req_ram && internal_ram_redirect_bit) |=> tgt_sel == mmd_pkg::SEL_EXT)
      else $error("redirected ram alias not external");
   a_upper_regs: assert property (
      s_near_req ##0 mmd_pkg::mmd_in_range(req_of, mmd_pkg::UREG_LO, mmd_pkg::UREG_HI)
      |=> tgt_sel == mmd_pkg::SEL_REG)
      else $error("upper register ram not internal");
   a_lower_regs: assert property (
      s_near_req ##0 mmd_pkg::mmd_in_range(req_of, mmd_pkg::LREG_LO, mmd_pkg::LREG_HI)
      |=> tgt_sel == mmd_pkg::SEL_REG)
      else $error("lower register file not internal");
   a_far_external: assert property (
      acc_valid && !(acc_fetch && size_mode_reg) && req_pg == mmd_pkg::PAGE_FAR1
      |=> tgt_sel == mmd_pkg::SEL_EXT)
      else $error("far data not external");
   a_a17_port: assert property (
      tgt_valid |-> extended_address_port[1] == tgt_addr[17])
      else $error("port bit 1 differs from a17");
   a_boot_page: assert property (
      s_top_req |=> extended_address_port == 4'hf)
      else $error("page ffh not shown as low page bits");
   a_mode_held: assert property (
      state_reg == mmd_pkg::ST_RUN ##1 1'b1 |-> $stable(size_mode_reg)
                                             && $stable(rom_alias_enable))
      else $error("latched size mode changed");
   a_sfr_internal: assert property (
      s_near_req ##0 mmd_pkg::mmd_in_range(req_of, mmd_pkg::SFR_LO, mmd_pkg::SFR_HI)
      |=> tgt_sel == mmd_pkg::SEL_REG)
      else $error("sfr range not internal");
   a_sel_onehot: assert property (
      tgt_valid |-> $onehot(tgt_sel))
      else $error("target select not one-hot");
   a_apb_answer: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not in first access cycle");
endmodule : mmd_decoder
`default_nettype wire

// ---- common/mmd_pkg.sv ----
`default_nettype none
package mmd_pkg;
   // ----------------------------------------
   // address map, split as page and offset
   // ----------------------------------------
   localparam logic [7:0]  PAGE_NEAR = 8'h00;
   localparam logic [7:0]  PAGE_FAR1 = 8'h01;
   localparam logic [7:0]  PAGE_TOP  = 8'hff;
   localparam logic [15:0] LREG_LO   = 16'h0000;
   localparam logic [15:0] LREG_HI   = 16'h00ff;
   localparam logic [15:0] UREG_LO   = 16'h0100;
   localparam logic [15:0] UREG_HI   = 16'h03ff;
   localparam logic [15:0] INTERNAL_RAM_REDIRECT_BIT_LO   = 16'h0400;
   localparam logic [15:0] INTERNAL_RAM_REDIRECT_BIT_HI   = 16'h05ff;
   localparam logic [15:0] SFR_LO    = 16'h1f00;
   localparam logic [15:0] SFR_HI    = 16'h1fff;
   localparam logic [15:0] ROM_LO    = 16'h2000;
   localparam logic [15:0] ROM_HI    = 16'h9fff;
   // ----------------------------------------
   // one-hot target selects
   // ----------------------------------------
   localparam logic [3:0]  SEL_REG   = 4'h1;
   localparam logic [3:0]  SEL_INTERNAL_RAM_REDIRECT_BIT  = 4'h2;
   localparam logic [3:0]  SEL_IROM  = 4'h4;
   localparam logic [3:0]  SEL_EXT   = 4'h8;
   // ----------------------------------------
   // apb registers and fields
   // ----------------------------------------
   localparam logic [11:0] OFS_CFG     = 12'h000;
   localparam logic [11:0] OFS_IRAMCON = 12'h004;
   localparam logic [11:0] OFS_STAT    = 12'h008;
   localparam int          CFG_SIZE    = 0;
   localparam int          CFG_FOLD    = 1;
   localparam int          CFG_EXTPIN  = 2;
   localparam int          CFG_RUN     = 3;
   localparam int          INTERNAL_RAM_REDIRECT_BIT_REDIR  = 6;
   localparam int          STAT_CNT_LO = 8;
   localparam logic [7:0]  IRAMCON_RST = 8'h00;
   localparam logic [15:0] CNT_RST     = 16'h0000;
   localparam logic [15:0] CNT_ONE     = 16'h0001;

   typedef enum logic [1:0] {ST_HOLD = 2'b00, ST_RUN = 2'b01} mmd_state_t;

   function automatic logic mmd_in_range(input logic [15:0] ofs,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      mmd_in_range = (ofs >= lo) && (ofs <= hi);
   endfunction : mmd_in_range
endpackage : mmd_pkg
`default_nettype wire

// ---- common/mmd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mmd_if;
   logic [23:0] addr;
   logic        fetch;
   logic        size_mode;
   logic        alias_en;
   logic        ext_pin_n;
   logic        redir;
   logic [3:0]  sel;
   logic [23:0] eff_addr;
   modport route (input addr, fetch, size_mode, alias_en, ext_pin_n, redir,
                  output sel, eff_addr);
   modport core  (output addr, fetch, size_mode, alias_en, ext_pin_n, redir,
                  input sel, eff_addr);
endinterface : mmd_if
`default_nettype wire

// ---- hdl/mmd_route.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmd_route
(
   mmd_if.route bus
);
   function automatic logic [3:0] mmd_target(input logic [23:0] a,
                                             input logic alias_en,
                                             input logic ext_pin_n,
                                             input logic redir);
      logic [7:0]  pg;
      logic [15:0] of;
      logic        rom;
      pg  = a[23:16];
      of  = a[15:0];
      rom = mmd_pkg::mmd_in_range(of, mmd_pkg::ROM_LO, mmd_pkg::ROM_HI);
      mmd_target = mmd_pkg::SEL_EXT;
      if (pg == mmd_pkg::PAGE_NEAR)
      begin
         if (mmd_pkg::mmd_in_range(of, mmd_pkg::LREG_LO, mmd_pkg::UREG_HI) ||
             mmd_pkg::mmd_in_range(of, mmd_pkg::SFR_LO, mmd_pkg::SFR_HI))
            mmd_target = mmd_pkg::SEL_REG;
         else if (mmd_pkg::mmd_in_range(of, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_LO, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_HI))
            mmd_target = mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT;
         else if (rom && alias_en && ext_pin_n)
            mmd_target = mmd_pkg::SEL_IROM;
      end
      else if (pg == mmd_pkg::PAGE_TOP)
      begin
         if (mmd_pkg::mmd_in_range(of, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_LO, mmd_pkg::INTERNAL_RAM_REDIRECT_BIT_HI))
            mmd_target = redir ? mmd_pkg::SEL_EXT : mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT;
         else if (rom && ext_pin_n)
            mmd_target = mmd_pkg::SEL_IROM;
      end
   endfunction : mmd_target

   always_comb
   begin
      bus.eff_addr = (bus.fetch && bus.size_mode) ? {mmd_pkg::PAGE_TOP, bus.addr[15:0]}
                                                   : bus.addr;
      bus.sel = mmd_target(bus.eff_addr, bus.alias_en, bus.ext_pin_n, bus.redir);
   end
endmodule : mmd_route
`default_nettype wire

// ---- tb/mmd_ext_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// external parts on the far side of the decoder: ram below a17, flash above, boot flash
module mmd_ext_model
#(
   parameter int LATCHES  = 2,
   parameter int BUS_MODE = 1
)
(
   // decoder target side
   input  wire logic        pclk,
   input  wire logic        tgt_valid,
   input  wire logic [3:0]  tgt_sel,
   input  wire logic [23:0] tgt_addr,
   input  wire logic [3:0]  extended_address_port,
   // part selection tallies
   output var  int          n_ram,
   output var  int          n_flash,
   output var  int          n_boot,
   output var  logic        timing_ok
);
   assign timing_ok = (LATCHES >= 2) || (BUS_MODE == 0) || (BUS_MODE == 3);

   // one process owns the tallies, so each has a single driver
   // a17 picks part, page ff is boot image
   initial
   begin
      n_ram = 0;
      n_flash = 0;
      n_boot = 0;
      forever
      begin
         @(posedge pclk);
         if (tgt_valid && tgt_sel == mmd_pkg::SEL_EXT)
         begin
            if (tgt_addr[23:16] == 8'hff)
               n_boot <= n_boot + 1;
            else if (extended_address_port[1])
               n_flash <= n_flash + 1;
            else
               n_ram <= n_ram + 1;
         end
      end
   end
endmodule : mmd_ext_model
`default_nettype wire

// ---- tb/mmd_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        memory_size_mode_bit, rom_fold_select_bit, external_access_pin_n;
   logic        acc_valid, acc_fetch, tgt_valid, rerr, size_l, timing_ok;
   logic [23:0] acc_addr, tgt_addr;
   logic [3:0]  tgt_sel, extended_address_port;
   int          n_fail, n_tests, ext_cnt, n_ram, n_flash, n_boot, e_ram, e_flash, e_boot;

   mmd_decoder uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .memory_size_mode_bit(memory_size_mode_bit),
      .rom_fold_select_bit(rom_fold_select_bit), .external_access_pin_n(external_access_pin_n),
      .acc_valid(acc_valid), .acc_fetch(acc_fetch), .acc_addr(acc_addr),
      .tgt_valid(tgt_valid), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr),
      .extended_address_port(extended_address_port));

   mmd_ext_model ext (.pclk(pclk), .tgt_valid(tgt_valid), .tgt_sel(tgt_sel),
      .tgt_addr(tgt_addr), .extended_address_port(extended_address_port),
      .n_ram(n_ram), .n_flash(n_flash), .n_boot(n_boot), .timing_ok(timing_ok));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // request held until the edge that samples pready; data taken at that edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 16)
         n_fail++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      chk(rdata, exp);
      chk({31'h0, rerr}, {31'h0, exp_err});
   endtask : rd

   // one access; the answer stands in the cycle after the taking edge
   task acc(input logic f, input logic [23:0] a, input logic [3:0] es);
      logic [23:0] eff;
      eff = (f && size_l) ? {8'hff, a[15:0]} : a;
      @(posedge pclk);
      acc_valid <= 1'b1;
      acc_fetch <= f;
      acc_addr <= a;
      @(posedge pclk);
      acc_valid <= 1'b0;
      @(posedge pclk);
      chk({31'h0, tgt_valid}, 32'h1);
      chk({28'h0, tgt_sel}, {28'h0, es});
      chk({8'h0, tgt_addr}, {8'h0, eff});
      chk({28'h0, extended_address_port}, {28'h0, eff[19:16]});
      if (es == mmd_pkg::SEL_EXT)
      begin
         ext_cnt++;
         if (eff[23:16] == 8'hff)
            e_boot++;
         else if (eff[17])
            e_flash++;
         else
            e_ram++;
      end
   endtask : acc

   task rst(input logic s, input logic f);
      @(posedge pclk);
      presetn <= 1'b0;
      memory_size_mode_bit <= s;
      rom_fold_select_bit <= f;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      size_l = s;
      ext_cnt = 0;
   endtask : rst

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      #200000;
      n_fail++;
      end_of_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, acc_valid, acc_fetch} = 6'h0;
      {paddr, pwdata, acc_addr} = 68'h0;
      {memory_size_mode_bit, rom_fold_select_bit, external_access_pin_n} = 3'b111;
      {n_fail, n_tests, ext_cnt, e_ram, e_flash, e_boot} = 192'h0;
      size_l = 1'b0;
      rst(1'b1, 1'b1);
      // strap moves after release and must not take effect
      memory_size_mode_bit <= 1'b0;
      acc(1'b1, 24'h002000, mmd_pkg::SEL_IROM);
      acc(1'b1, 24'h05a123, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h002000, mmd_pkg::SEL_IROM);
      acc(1'b0, 24'h009fff, mmd_pkg::SEL_IROM);
      acc(1'b0, 24'h00a000, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h000000, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h0000ff, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h000100, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h0003ff, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h001f00, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h001fff, mmd_pkg::SEL_REG);
      acc(1'b0, 24'h001eff, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h000400, mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT);
      acc(1'b0, 24'hff05ff, mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT);
      acc(1'b0, 24'hff0600, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h010000, mmd_pkg::SEL_EXT);
      rd(mmd_pkg::OFS_CFG, 32'h0000000f, 1'b0);
      apb(1'b1, mmd_pkg::OFS_CFG, 32'h00000000);
      rd(mmd_pkg::OFS_CFG, 32'h0000000f, 1'b0);
      rd(12'h00c, 32'h00000000, 1'b1);
      external_access_pin_n <= 1'b0;
      acc(1'b0, 24'hff2000, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h002000, mmd_pkg::SEL_EXT);
      acc(1'b1, 24'h009fff, mmd_pkg::SEL_EXT);
      rd(mmd_pkg::OFS_CFG, 32'h0000000b, 1'b0);
      external_access_pin_n <= 1'b1;
      rst(1'b0, 1'b0);
      acc(1'b1, 24'h032345, mmd_pkg::SEL_EXT);
      acc(1'b1, 24'h012345, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h002000, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'hff2000, mmd_pkg::SEL_IROM);
      acc(1'b1, 24'hff3000, mmd_pkg::SEL_IROM);
      rd(mmd_pkg::OFS_CFG, 32'h0000000c, 1'b0);
      rd(mmd_pkg::OFS_IRAMCON, 32'h00000000, 1'b0);
      apb(1'b1, mmd_pkg::OFS_IRAMCON, 32'h00000040);
      rd(mmd_pkg::OFS_IRAMCON, 32'h00000040, 1'b0);
      acc(1'b0, 24'hff0400, mmd_pkg::SEL_EXT);
      acc(1'b0, 24'h000400, mmd_pkg::SEL_INTERNAL_RAM_REDIRECT_BIT);
      // select field reads zero once the access cycle has passed
      rd(mmd_pkg::OFS_STAT, {8'h0, ext_cnt[15:0], 8'h00}, 1'b0);
      apb(1'b1, mmd_pkg::OFS_STAT, 32'h00000000);
      rd(mmd_pkg::OFS_STAT, 32'h00000000, 1'b0);
      chk(n_boot, e_boot);
      chk(n_flash, e_flash);
      chk(n_ram, e_ram);
      chk({31'h0, timing_ok}, 32'h1);
      end_of_test();
   end
endmodule : mmd_decoder_tb
`default_nettype wire
